// *** shared/ssp_defs.svh ***
// Constants for the serial programming port: opcodes, sizes, timing.
// Assumes inclusion by bare name from design files.
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
`define SSP_CLK_MHZ        200
`define SSP_EN_B1          8'hAC
`define SSP_EN_B2          8'h53
`define SSP_ERASED         8'hFF
`define SSP_OP_RD_FLASH    8'h20
`define SSP_OP_LD_PAGE     8'h40
`define SSP_OP_WR_PAGE     8'h4C
`define SSP_OP_RD_EE       8'hA0
`define SSP_OP_WR_EE       8'hC0
`define SSP_B2_ERASE       3'h4
`define SSP_H_BIT          3
`define SSP_FLASH_AW       13
`define SSP_EE_AW          9
`define SSP_PAGE_AW        6
`define SSP_PAGE_HI_AW     7
`define SSP_FLASH_US       4500
`define SSP_EE_US          9000
`define SSP_ERASE_US       9000
`endif

// *** shared/ssp_pkg.sv ***
// Types shared by the serial programming port files.
// Assumes ssp_defs.svh compiled alongside.
package ssp_pkg;
   typedef enum logic [4:0] {
      SSP_IDLE  = 5'h01,
      SSP_ERASE = 5'h02,
      SSP_FPROG = 5'h04,
      SSP_EPROG = 5'h08,
      SSP_CLEAR = 5'h10
   } ssp_nv_state_t;
endpackage

// *** hdl/ssp_mem.sv ***
// Byte-wide single port memory with registered read data.
// Assumes one synchronous clock; contents are not reset.
`timescale 1ns/1ps
`default_nettype none
module ssp_mem #(
   parameter int AW = 8
) (
   input  wire logic          sys_clk_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [7:0]    wdata_in,
   output logic      [7:0]    rdata_out
);
   logic [7:0] mem_ff [0:(1<<AW)-1];
   logic [7:0] rdata_ff;
   // Read first, not write first: a cell written this cycle reads back its old value
   always_ff @(posedge sys_clk_in) begin
      if (we_in) begin
         mem_ff[addr_in] <= wdata_in;
      end
      rdata_ff <= mem_ff[addr_in];
   end
   assign rdata_out = rdata_ff;
endmodule // ssp_mem
`default_nettype wire

// *** hdl/ssp_sync.sv ***
// Two flip-flop synchroniser for one pin level.
// Assumes an asynchronous pin; output is safe in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
   parameter logic INIT = 1'b0
) (
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic d_in,
   output logic      q_out
);
   logic meta_ff;
   logic q_ff;
   // First stage is read only by the second
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_ff <= INIT;
         q_ff    <= INIT;
      end else begin
         meta_ff <= d_in;
         q_ff    <= meta_ff;
      end
   end
   assign q_out = q_ff;
endmodule // ssp_sync
`default_nettype wire

// *** hdl/ssp_port.sv ***
// Serial in-system programming port: SPI slave into flash and EEPROM.
// Assumes sys_clk runs (oversampling the link clock) and that the device
// reset pin arrives as tgt_reset_in (low = programming allowed).
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"
module ssp_port
   import ssp_pkg::*;
#(
   parameter int FLASH_CYC = `SSP_FLASH_US * `SSP_CLK_MHZ,
   parameter int EE_CYC    = `SSP_EE_US * `SSP_CLK_MHZ,
   parameter int ERASE_CYC = `SSP_ERASE_US * `SSP_CLK_MHZ
) (
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic tgt_reset_in,
   input  wire logic sck_in,
   input  wire logic mosi_in,
   output logic      miso_out,
   output logic      miso_oe_out,
   output logic      prog_mode_out,
   output logic      busy_out
);
   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic sck_s;
   logic mosi_s;
   logic trst_s;
   ssp_sync #(.INIT(1'b0)) u_sck (.sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in), .d_in(sck_in), .q_out(sck_s));
   ssp_sync #(.INIT(1'b0)) u_mosi (.sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in), .d_in(mosi_in), .q_out(mosi_s));
   ssp_sync #(.INIT(1'b1)) u_trst (.sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in), .d_in(tgt_reset_in), .q_out(trst_s));

   ////////////////////////////////////////////////////////////////////
   // Shift engine: 32-bit instruction, byte counting, MISO shifter
   logic        sck_d_ff,  nxt_sck_d;
   logic [4:0]  bit_ff,    nxt_bit;
   logic [31:0] ins_ff,    nxt_ins;
   logic [7:0]  tx_ff,     nxt_tx;
   logic        miso_ff,   nxt_miso;
   logic        done_ff,   nxt_done;
   logic        active;
   logic        rise;
   logic        fall;
   logic [7:0]  rd_byte;
   logic        rd_cmd3;

   // Active only while device reset is held low
   assign active = !trst_s;
   assign rise   = sck_s && !sck_d_ff;
   assign fall   = !sck_s && sck_d_ff;

   // Edge detection on synchronised clock, MSB-first shift
   // Only works while sys_clk runs well above the link clock
   always_comb begin
      nxt_sck_d = sck_s;
      nxt_bit   = bit_ff;
      nxt_ins   = ins_ff;
      nxt_tx    = tx_ff;
      nxt_miso  = miso_ff;
      nxt_done  = 1'b0;
      if (!active) begin
         nxt_bit  = 5'h00;
         nxt_miso = 1'b0;
      end else if (rise) begin
         nxt_ins = {ins_ff[30:0], mosi_s};
         nxt_bit = bit_ff + 5'h01;
         nxt_done = (bit_ff == 5'h1F);
      end else if (fall) begin
         // Reload at each byte boundary, else shift
         if (bit_ff[2:0] == 3'h0 && bit_ff != 5'h00) begin
            if (bit_ff == 5'h10) begin
               // Third byte: echo of byte two; read data goes out in byte four
               nxt_tx = ins_ff[7:0];
            end else if (bit_ff == 5'h18) begin
               nxt_tx = rd_cmd3 ? rd_byte : 8'h00;
            end else begin
               nxt_tx = 8'h00;
            end
            nxt_miso = nxt_tx[7];
            nxt_tx   = {nxt_tx[6:0], 1'b0};
         end else begin
            nxt_miso = tx_ff[7];
            nxt_tx   = {tx_ff[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sck_d_ff <= 1'b0;
         bit_ff   <= 5'h00;
         ins_ff   <= 32'h0000_0000;
         tx_ff    <= 8'h00;
         miso_ff  <= 1'b0;
         done_ff  <= 1'b0;
      end else begin
         sck_d_ff <= nxt_sck_d;
         bit_ff   <= nxt_bit;
         ins_ff   <= nxt_ins;
         tx_ff    <= nxt_tx;
         miso_ff  <= nxt_miso;
         done_ff  <= nxt_done;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Decode of the captured instruction
   logic [7:0] op;
   logic [7:0] b2;
   logic [7:0] b3;
   logic [7:0] b4;
   assign op = ins_ff[31:24];
   assign b2 = ins_ff[23:16];
   assign b3 = ins_ff[15:8];
   assign b4 = ins_ff[7:0];

   // Flash byte address: word address a:b plus high/low select
   function automatic logic [`SSP_FLASH_AW-1:0] fl_addr(
      input logic [7:0] o, input logic [7:0] hi, input logic [7:0] lo);
      fl_addr = {hi[3:0], lo, o[`SSP_H_BIT]};
   endfunction

   // Read lead-in: after three bytes the header sits in the low 24 bits
   logic [7:0]               rop;
   logic [7:0]               rhi;
   logic [7:0]               rlo;
   logic [`SSP_FLASH_AW-1:0] rd_fa;
   assign rop   = ins_ff[23:16];
   assign rhi   = ins_ff[15:8];
   assign rlo   = ins_ff[7:0];
   assign rd_fa = fl_addr(rop, rhi, rlo);

   ////////////////////////////////////////////////////////////////////
   // Programming enable, page buffer and nonvolatile sequencer
   logic                      en_ff,    nxt_en;
   ssp_nv_state_t             st_ff,    nxt_st;
   logic [31:0]               cnt_ff,   nxt_cnt;
   logic [`SSP_FLASH_AW-1:0]  cur_ff,   nxt_cur;
   logic [`SSP_PAGE_HI_AW-1:0] pg_ff,   nxt_pg;
   logic [`SSP_EE_AW-1:0]     eea_ff,   nxt_eea;
   logic [7:0]                eed_ff,   nxt_eed;
   logic [7:0]                pbuf_ff [0:127];
   logic                      pb_we;
   logic [6:0]                pb_idx;
   logic                      f_we, e_we;
   logic [`SSP_FLASH_AW-1:0]  f_addr;
   logic [`SSP_EE_AW-1:0]     e_addr;
   logic [7:0]                f_wd, e_wd, f_rd, e_rd;
   logic                      busy;
   logic                      is_en, is_erase, is_ld, is_wp, is_we;

   assign is_en    = op == `SSP_EN_B1 && b2 == `SSP_EN_B2;
   assign is_erase = op == `SSP_EN_B1 && b2[7:5] == `SSP_B2_ERASE;
   assign is_ld    = (op & 8'hF7) == `SSP_OP_LD_PAGE;
   assign is_wp    = op == `SSP_OP_WR_PAGE;
   assign is_we    = op == `SSP_OP_WR_EE;
   assign busy     = st_ff != SSP_IDLE;

   // Sequencer: the timer stands in for the self-timed array write
   always_comb begin
      nxt_en  = en_ff;
      nxt_st  = st_ff;
      nxt_cnt = cnt_ff;
      nxt_cur = cur_ff;
      nxt_pg  = pg_ff;
      nxt_eea = eea_ff;
      nxt_eed = eed_ff;
      pb_we   = 1'b0;
      pb_idx  = {b3[5:0], op[`SSP_H_BIT]};
      if (!active) begin
         nxt_en = 1'b0;
      end else if (done_ff) begin
         if (is_en) begin
            nxt_en = 1'b1;
         end else if (en_ff && !busy) begin
            if (is_erase) begin
               nxt_st  = SSP_ERASE;
               nxt_cur = '0;
            end else if (is_ld) begin
               pb_we = 1'b1;
            end else if (is_wp) begin
               nxt_st  = SSP_FPROG;
               nxt_pg  = {b2[4:0], b3[7:6]};
               nxt_cur = '0;
            end else if (is_we) begin
               nxt_st  = SSP_EPROG;
               nxt_eea = {b2[0], b3};
               nxt_eed = b4;
               nxt_cnt = 32'h0;
            end
         end
      end
      // Array writes proceed even after reset release to avoid tearing
      case (st_ff)
         SSP_IDLE: begin
            nxt_cnt = 32'h0;
         end
         SSP_ERASE: begin
            nxt_cur = cur_ff + 1'b1;
            nxt_cnt = cnt_ff + 32'h1;
            if (cnt_ff >= 32'(ERASE_CYC - 1)) begin
               nxt_st = SSP_IDLE;
            end
         end
         SSP_FPROG: begin
            if (cur_ff[6:0] != 7'h7F) begin
               nxt_cur = cur_ff + 1'b1;
            end
            nxt_cnt = cnt_ff + 32'h1;
            if (cnt_ff >= 32'(FLASH_CYC - 1)) begin
               nxt_st = SSP_IDLE;
            end
         end
         SSP_EPROG: begin
            nxt_cnt = cnt_ff + 32'h1;
            if (cnt_ff >= 32'(EE_CYC - 1)) begin
               nxt_st = SSP_IDLE;
            end
         end
         default: begin
            nxt_st = SSP_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         en_ff  <= 1'b0;
         st_ff  <= SSP_IDLE;
         cnt_ff <= 32'h0;
         cur_ff <= '0;
         pg_ff  <= '0;
         eea_ff <= '0;
         eed_ff <= 8'h00;
      end else begin
         en_ff  <= nxt_en;
         st_ff  <= nxt_st;
         cnt_ff <= nxt_cnt;
         cur_ff <= nxt_cur;
         pg_ff  <= nxt_pg;
         eea_ff <= nxt_eea;
         eed_ff <= nxt_eed;
      end
   end

   // Page buffer kept in flops; it is read every cycle during commit
   always_ff @(posedge sys_clk_in) begin
      if (pb_we) begin
         pbuf_ff[pb_idx] <= b4;
      end
   end

   // Array ports: sequencer writes, otherwise read address from command
   always_comb begin
      f_we   = 1'b0;
      e_we   = 1'b0;
      f_wd   = `SSP_ERASED;
      e_wd   = `SSP_ERASED;
      f_addr = rd_fa;
      e_addr = {rhi[0], rlo};
      if (st_ff == SSP_ERASE) begin
         f_we   = 1'b1;
         e_we   = 1'b1;
         f_addr = cur_ff;
         e_addr = cur_ff[`SSP_EE_AW-1:0];
      end else if (st_ff == SSP_FPROG) begin
         f_we   = 1'b1;
         f_addr = {pg_ff[5:0], cur_ff[6:0]};
         f_wd   = pbuf_ff[cur_ff[6:0]];
      end else if (st_ff == SSP_EPROG && cnt_ff == 32'h1) begin
         e_we   = 1'b1;
         e_addr = eea_ff;
         e_wd   = eed_ff;
      end
   end

   ssp_mem #(.AW(`SSP_FLASH_AW)) u_flash (.sys_clk_in(sys_clk_in),
      .we_in(f_we), .addr_in(f_addr), .wdata_in(f_wd),
      .rdata_out(f_rd));
   ssp_mem #(.AW(`SSP_EE_AW)) u_ee (.sys_clk_in(sys_clk_in),
      .we_in(e_we), .addr_in(e_addr), .wdata_in(e_wd),
      .rdata_out(e_rd));

   // Read data, masked to 0xFF while the polled location is programming
   always_comb begin
      rd_cmd3 = 1'b0;
      rd_byte = 8'h00;
      if ((rop & 8'hF7) == `SSP_OP_RD_FLASH) begin
         rd_cmd3 = 1'b1;
         rd_byte = f_rd;
         if (st_ff == SSP_FPROG && rd_fa[12:7] == pg_ff[5:0]) begin
            rd_byte = `SSP_ERASED;
         end
      end else if (rop == `SSP_OP_RD_EE) begin
         rd_cmd3 = 1'b1;
         rd_byte = e_rd;
         if (st_ff == SSP_EPROG && {rhi[0], rlo} == eea_ff) begin
            rd_byte = `SSP_ERASED;
         end
      end
      if (st_ff == SSP_ERASE) begin
         rd_byte = `SSP_ERASED;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Registered outputs
   logic oe_ff;
   logic pm_ff;
   logic bz_ff;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         oe_ff <= 1'b0;
         pm_ff <= 1'b0;
         bz_ff <= 1'b0;
      end else begin
         oe_ff <= active;
         pm_ff <= nxt_en;
         bz_ff <= nxt_st != SSP_IDLE;
      end
   end
   assign miso_out      = miso_ff;
   assign miso_oe_out   = oe_ff;
   assign prog_mode_out = pm_ff;
   assign busy_out      = bz_ff;

   ////////////////////////////////////////////////////////////////////
   // Checks
   chk_no_op_unenabled: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) !en_ff && st_ff == SSP_IDLE |=>
      st_ff == SSP_IDLE) else $error("operation without enable");
   chk_reset_exits: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) trst_s |=> !en_ff)
      else $error("programming mode kept after reset");
   chk_bit_clear: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) trst_s |=> bit_ff == 5'h00)
      else $error("partial instruction kept");
   chk_sample_rise: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) active && rise |=>
      ins_ff[0] == $past(mosi_s)) else $error("bad sample");
   chk_ee_timed: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) $rose(st_ff == SSP_EPROG) |->
      st_ff == SSP_EPROG [*8]) else $error("eeprom too short");
   chk_erase_ff: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) st_ff == SSP_ERASE |->
      f_we && f_wd == 8'hFF && e_wd == 8'hFF)
      else $error("erase not 0xFF");
   chk_poll_ee: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) st_ff == SSP_EPROG && rop == 8'hA0 &&
      {rhi[0], rlo} == eea_ff |-> rd_byte == 8'hFF)
      else $error("eeprom poll not 0xFF");
   chk_poll_flash: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) st_ff == SSP_FPROG && rd_cmd3 &&
      rop != 8'hA0 && rd_fa[12:7] == pg_ff[5:0] |-> rd_byte == 8'hFF)
      else $error("flash poll not 0xFF");
   chk_echo: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) active && fall && bit_ff == 5'h10 |=>
      miso_ff == $past(ins_ff[7])) else $error("echo wrong");
   cov_enable: cover property (@(posedge sys_clk_in) $rose(en_ff));
   cov_erase: cover property (@(posedge sys_clk_in) st_ff == SSP_ERASE);
   cov_page: cover property (@(posedge sys_clk_in) st_ff == SSP_FPROG);
   cov_ee: cover property (@(posedge sys_clk_in) st_ff == SSP_EPROG);
endmodule // ssp_port
`default_nettype wire

// *** bench/ssp_prog_model.sv ***
// Programmer model for the serial programming port: drives SCK and MOSI.
// Assumes the bench calls xfer from one process; clock is the bench clock.
`timescale 1ns/1ps
`default_nettype none
module ssp_prog_model #(
   parameter int HALF_CYC = 16
) (
   input  wire logic sys_clk_in,
   input  wire logic miso_in,
   output var  logic sck_out,
   output var  logic mosi_out
);
   ////////////////////////////////////////////////////////////////////////
   // Idle levels: clock stands low outside frames
   initial begin
      sck_out  = 1'b0;
      mosi_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Shift n bits MSB first; a short count models an aborted frame
   task automatic xfer(input logic [31:0] cmd, input int n,
                       output logic [31:0] rsp);
      rsp = 32'h0;
      for (int i = 31; i > 31 - n; i--) begin
         @(negedge sys_clk_in);
         mosi_out = cmd[i];
         repeat (HALF_CYC) @(negedge sys_clk_in);
         sck_out = 1'b1;
         rsp = {rsp[30:0], miso_in};
         repeat (HALF_CYC) @(negedge sys_clk_in);
         sck_out = 1'b0;
      end
      // Released data line must not look like a held value
      mosi_out = ~mosi_out;
   endtask
endmodule // ssp_prog_model
`default_nettype wire

// *** bench/ssp_port_tb.sv ***
// Self-checking bench for the serial programming port.
// Assumes ssp_port and ssp_prog_model compiled; short write times set here.
`timescale 1ns/1ps
`default_nettype none
module ssp_port_tb;
   localparam int FLASH_N = 3000;
   localparam int EE_N    = 3000;
   localparam int ERASE_N = 8200;
   logic        sys_clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        tgt_reset_in = 1'b0;
   logic        sck;
   logic        mosi;
   logic        miso;
   logic        miso_oe;
   logic        prog_mode;
   logic        busy;
   logic [31:0] rsp;
   int          n_mismatch = 0;
   int          n_checks = 0;

   ////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   always #2.5 sys_clk_in = ~sys_clk_in;

   ssp_port #(.FLASH_CYC(FLASH_N), .EE_CYC(EE_N), .ERASE_CYC(ERASE_N)) i_dut (
      .sys_clk_in   (sys_clk_in),
      .rst_n_in     (rst_n_in),
      .tgt_reset_in (tgt_reset_in),
      .sck_in       (sck),
      .mosi_in      (mosi),
      .miso_out     (miso),
      .miso_oe_out  (miso_oe),
      .prog_mode_out(prog_mode),
      .busy_out     (busy)
   );

   ssp_prog_model i_prog (
      .sys_clk_in(sys_clk_in),
      .miso_in   (miso),
      .sck_out   (sck),
      .mosi_out  (mosi)
   );

   ////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic send(input logic [31:0] c);
      i_prog.xfer(c, 32, rsp);
      repeat (2) @(negedge sys_clk_in);
   endtask

   task automatic rd_chk(input logic [23:0] c, input logic [7:0] exp);
      i_prog.xfer({c, 8'h00}, 32, rsp);
      chk(rsp[7:0], exp);
   endtask

   // Polls busy instead of a fixed write delay; bounded
   task automatic wait_free(input int lim);
      int k;
      k = 0;
      while (busy !== 1'b0 && k < lim) begin
         @(negedge sys_clk_in);
         k++;
      end
      if (k >= lim) begin
         n_mismatch++;
         $display("[ERR] %0t: busy never cleared", $time);
         wrap_up();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      repeat (4) @(negedge sys_clk_in);
      chk({5'h00, miso_oe, prog_mode, busy}, 8'h00);
      rst_n_in = 1'b1;
      // Settling wait before enable, scaled down for simulation
      repeat (6) @(negedge sys_clk_in);
      chk({7'h00, miso_oe}, 8'h01);
   endtask

   // Writes and erase before the enable instruction are ignored
   task automatic t_locked;
      send(32'hC0_00_05_5A);
      chk({6'h00, prog_mode, busy}, 8'h00);
      send(32'hAC_80_00_00);
      chk({6'h00, prog_mode, busy}, 8'h00);
   endtask

   task automatic t_enable;
      send(32'hAC_53_00_00);
      chk(rsp[15:8], 8'h53);
      chk({7'h00, prog_mode}, 8'h01);
   endtask

   // Erase then sweep flash corners and EEPROM cells 0x005 and 0x1FF
   task automatic t_erase;
      send(32'hAC_80_00_00);
      chk({7'h00, busy}, 8'h01);
      wait_free(ERASE_N + 200);
      rd_chk(24'hA0_00_05, 8'hFF);
      rd_chk(24'hA0_01_FF, 8'hFF);
      rd_chk(24'h20_00_00, 8'hFF);
      rd_chk(24'h28_0F_FF, 8'hFF);
   endtask

   // Rewrite without erase must still land the new value
   task automatic t_eeprom;
      send(32'hC0_01_23_0F);
      chk({7'h00, busy}, 8'h01);
      rd_chk(24'hA0_01_23, 8'hFF);
      chk({7'h00, busy}, 8'h01);
      wait_free(EE_N + 200);
      rd_chk(24'hA0_01_23, 8'h0F);
      rd_chk(24'hA0_01_22, 8'hFF);
      send(32'hC0_01_23_F0);
      wait_free(EE_N + 200);
      rd_chk(24'hA0_01_23, 8'hF0);
   endtask

   // Fill first and last word of page 1, commit, poll and verify
   task automatic t_flash;
      send(32'h40_00_00_11);
      send(32'h48_00_00_22);
      send(32'h40_00_3F_33);
      send(32'h48_00_3F_44);
      send(32'h4C_00_40_00);
      chk({7'h00, busy}, 8'h01);
      rd_chk(24'h28_00_7F, 8'hFF);
      wait_free(FLASH_N + 200);
      rd_chk(24'h20_00_40, 8'h11);
      rd_chk(24'h28_00_40, 8'h22);
      rd_chk(24'h20_00_7F, 8'h33);
      rd_chk(24'h28_00_7F, 8'h44);
      rd_chk(24'h20_00_00, 8'hFF);
   endtask

   // Abort mid-frame, pulse reset, then relock and resynchronise
   task automatic t_abort;
      i_prog.xfer(32'hC0_01_23_55, 12, rsp);
      tgt_reset_in = 1'b1;
      repeat (6) @(negedge sys_clk_in);
      chk({6'h00, miso_oe, prog_mode}, 8'h00);
      tgt_reset_in = 1'b0;
      repeat (6) @(negedge sys_clk_in);
      send(32'hC0_01_23_00);
      chk({6'h00, prog_mode, busy}, 8'h00);
      send(32'hAC_53_00_00);
      chk(rsp[15:8], 8'h53);
      chk({7'h00, prog_mode}, 8'h01);
      rd_chk(24'hA0_01_23, 8'hF0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      t_reset();
      t_locked();
      t_enable();
      t_erase();
      t_eeprom();
      t_flash();
      t_abort();
      wrap_up();
   end
endmodule // ssp_port_tb
`default_nettype wire
